// *** dsacf_engine_model.sv ***
/* Behavioural transfer engine facing the register bank.
   Assumes the bench pulses kick one cycle per wanted item and
   fault one cycle per wanted FIFO fault. */
`timescale 1ns/100ps
`default_nettype none
module dsacf_engine_model (
    input  wire logic        clk,
    input  wire logic [7:0]  kick,
    input  wire logic [7:0]  fault,
    output logic      [7:0]  itemDone,
    output logic      [7:0]  fifoError,
    output logic      [23:0] fifoLevel,
    output logic      [63:0] chanReq
);
    always_ff @(posedge clk) begin
        itemDone  <= kick;
        fifoError <= fault;
    end
    // Steady levels: stream 0 at half level, channel 3 requesting
    assign fifoLevel = 24'h000002;
    assign chanReq   = 64'h8;
endmodule
`default_nettype wire

// *** dsacf_irq.sv ***
/*
 * Sticky interrupt status with a mask and one level interrupt line.
 * Assumes event pulses and the write strobes come from logic on the
 * same clock; software clears a status bit by writing a one to it.
 */
`timescale 1ns/100ps
`default_nettype none

module dsacf_irq (
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic [dsacf_pkg::NEVT-1:0]   evt,
    input  wire logic                         wrStatus,
    input  wire logic                         wrMask,
    input  wire logic [dsacf_pkg::NEVT-1:0]   wdata,
    output logic      [dsacf_pkg::NEVT-1:0]   status,
    output logic      [dsacf_pkg::NEVT-1:0]   mask,
    output logic                              irq
);
    import dsacf_pkg::*;

    dsacf_irq_s st_q;   // Registered state
    dsacf_irq_s st_d;   // Next state

    // Clear by one, but a new event in the same cycle survives
    always_comb begin
        st_d = st_q;
        if (wrStatus) begin
            st_d.status = st_q.status & ~wdata;
        end
        st_d.status = st_d.status | evt;
        if (wrMask) begin
            st_d.mask = wdata;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= RESET_IRQ;
        end else begin
            st_q <= st_d;
        end
    end

    assign status = st_q.status;
    assign mask   = st_q.mask;
    // Level line, no edge: stays up until software clears or masks
    assign irq    = |(st_q.status & st_q.mask);

    // Event beside a clear must still be seen
    AST_SET_WINS_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
        (wrStatus && |(evt & wdata)) |=> ((status & $past(evt)) == $past(evt)))
        else $error("event lost during status clear");

endmodule

`default_nettype wire

// *** dsacf_pkg.sv ***
/*
 * Shared constants and types for the per-stream register bank of the
 * eight-stream DMA controller: register offsets, field positions,
 * reset values and the encodings of direction and burst, with beats per burst.
 * Assumes a byte-addressed register port with twelve address bits and
 * 32-bit data, each register on one aligned word.
 */
package dsacf_pkg;

    // Geometry of the bank
    localparam int          NSTREAM        = 8;
    localparam int          NCHAN          = 8;
    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 32;
    localparam int          COUNT_W        = 16;
    localparam int          NEVT           = 2 * NSTREAM;

    // Byte offsets of stream 0; stream n adds n times the stride
    localparam logic [11:0] STREAM_STRIDE  = 12'h018;
    localparam logic [11:0] OFF_CFG        = 12'h010;
    localparam logic [11:0] OFF_COUNT      = 12'h014;
    localparam logic [11:0] OFF_PADDR      = 12'h018;
    localparam logic [11:0] OFF_FIRST_BUFFER_ADDRESS     = 12'h01c;
    localparam logic [11:0] OFF_SECOND_BUFFER_ADDRESS     = 12'h020;
    localparam logic [11:0] OFF_FCTRL      = 12'h024;
    // Interrupt registers, above the last stream
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h100;
    localparam logic [11:0] OFF_IRQ_MASK   = 12'h104;

    // Configuration register fields
    localparam int          CFG_EN_BIT     = 0;
    localparam int          CFG_DIR_LSB    = 6;
    localparam int          CFG_CIRC_BIT   = 8;
    localparam int          CFG_DBM_BIT    = 18;
    localparam int          CFG_TARG_BIT   = 19;
    localparam int          CFG_MBURST_LSB = 23;
    localparam int          CFG_REQUEST_CHANNEL_SELECT_LSB  = 25;
    // FIFO control register fields
    localparam int          FC_FTH_LSB     = 0;
    localparam int          FC_DMOFF_BIT   = 2;
    localparam int          FC_FIFO_LEVEL_STATUS_LSB    = 3;
    localparam int          FC_FIFO_ERROR_IRQ_ENABLE_BIT   = 7;

    // Transfer direction codes
    typedef enum logic [1:0] {
        DSACF_P2M  = 2'b00,
        DSACF_M2P  = 2'b01,
        DSACF_M2M  = 2'b10,
        DSACF_RSVD = 2'b11
    } dsacf_dir_e;

    // Memory burst codes
    typedef enum logic [1:0] {
        DSACF_SINGLE = 2'b00,
        DSACF_INCR4  = 2'b01,
        DSACF_INCR8  = 2'b10,
        DSACF_INCR16 = 2'b11
    } dsacf_burst_e;

    // Beats per memory burst
    localparam logic [4:0]  BEATS_SINGLE   = 5'h01;
    localparam logic [4:0]  BEATS_INCR4    = 5'h04;
    localparam logic [4:0]  BEATS_INCR8    = 5'h08;
    localparam logic [4:0]  BEATS_INCR16   = 5'h10;

    // One stream's stored state
    typedef struct packed {
        logic               en;
        dsacf_dir_e         dir;
        logic               circ;
        logic               double_buffer_mode;
        logic               target;
        dsacf_burst_e       mburst;
        logic [2:0]         request_channel_select;
        logic [15:0]        count;
        logic [15:0]        orig;
        logic [31:0]        paddr;
        logic [31:0]        first_buffer_address;
        logic [31:0]        second_buffer_address;
        logic [1:0]         fth;
        logic               dmOff;
        logic               fifo_error_irq_enable;
    } dsacf_stream_s;

    // Whole bank state
    typedef struct packed {
        dsacf_stream_s [NSTREAM-1:0] strm;
        logic [31:0]                 rdata;
    } dsacf_regs_s;

    // Interrupt block state
    typedef struct packed {
        logic [NEVT-1:0]   status;
        logic [NEVT-1:0]   mask;
    } dsacf_irq_s;

    // Values after reset
    localparam dsacf_regs_s RESET_REGS     = '0;
    localparam dsacf_irq_s  RESET_IRQ      = '0;

endpackage

// *** dsacf_regs.sv ***
/*
 * Per-stream register bank of an eight-stream DMA controller: stream
 * configuration, item counter with reload, peripheral and two memory
 * base addresses with write protection, FIFO control and status, and
 * the interrupt status and mask.
 * Assumes the transfer engine runs on the same clock, pulses itemDone
 * once per completed item and fifoError once per FIFO fault, and
 * reports the FIFO level code of each stream as a steady level.
 */
`timescale 1ns/100ps
`default_nettype none

module dsacf_regs (
    input  wire logic                                     clk,
    input  wire logic                                     nrst,
    input  wire logic [dsacf_pkg::ADDR_W-1:0]             regAddr,
    input  wire logic [dsacf_pkg::DATA_W-1:0]             regWdata,
    input  wire logic                                     regWr,
    input  wire logic                                     regRd,
    output logic      [dsacf_pkg::DATA_W-1:0]             regRdata,
    input  wire logic [dsacf_pkg::NSTREAM-1:0]            itemDone,
    input  wire logic [dsacf_pkg::NSTREAM-1:0]            fifoError,
    input  wire logic [3*dsacf_pkg::NSTREAM-1:0]          fifoLevel,
    input  wire logic [dsacf_pkg::NCHAN*dsacf_pkg::NSTREAM-1:0] chanReq,
    output logic      [dsacf_pkg::NSTREAM-1:0]            streamEnable,
    output logic      [dsacf_pkg::NSTREAM-1:0]            streamReq,
    output logic      [dsacf_pkg::NSTREAM-1:0]            directMode,
    output logic      [2*dsacf_pkg::NSTREAM-1:0]          transferDir,
    output logic      [5*dsacf_pkg::NSTREAM-1:0]          memBurstBeats,
    output logic      [3*dsacf_pkg::NSTREAM-1:0]          fifoThreshold,
    output logic      [32*dsacf_pkg::NSTREAM-1:0]         periphAddr,
    output logic      [32*dsacf_pkg::NSTREAM-1:0]         memAddr,
    output logic                                          irq
);
    import dsacf_pkg::*;

    dsacf_regs_s           st_q;        // Registered state
    dsacf_regs_s           st_d;        // Next state
    logic [NSTREAM-1:0]    doneEvt;     // Block of items finished
    logic [NSTREAM-1:0]    fifoErrEvt;  // FIFO faults let through
    logic [NEVT-1:0]       irqStatus;   // Sticky status view
    logic [NEVT-1:0]       irqMask;     // Mask view
    logic                  wrIrqStatus; // Write hits status
    logic                  wrIrqMask;   // Write hits mask

    // Byte address of a register in stream n
    // per-stream address map
    function automatic logic [ADDR_W-1:0] stAddr(input int n, input logic [11:0] off);
        return off + 12'(n) * STREAM_STRIDE;
    endfunction

    // Beats of one memory burst; direct mode always moves singly
    function automatic logic [4:0] burstBeats(input dsacf_burst_e code, input logic direct);
        logic [4:0] beats;
        beats = BEATS_SINGLE;
        unique case (code)
            DSACF_SINGLE: beats = BEATS_SINGLE;
            DSACF_INCR4:  beats = BEATS_INCR4;
            DSACF_INCR8:  beats = BEATS_INCR8;
            DSACF_INCR16: beats = BEATS_INCR16;
        endcase
        if (direct) begin
            beats = BEATS_SINGLE;
        end
        return beats;
    endfunction

    // Configuration word as software sees it
    function automatic logic [31:0] cfgView(input dsacf_stream_s s);
        logic [1:0] burst;
        burst = s.dmOff ? s.mburst : DSACF_SINGLE;
        return {4'h0, s.request_channel_select, burst, 3'h0, s.target, s.double_buffer_mode, 9'h000,
                s.circ, s.dir, 5'h00, s.en};
    endfunction

    // Register writes, counter and read mux, all streams in one pass
    always_comb begin
        dsacf_stream_s s;
        logic          wrCfg;
        logic          wrCnt;
        logic          wrPad;
        logic          wrM0;
        logic          wrM1;
        logic          wrFc;
        s       = '0;
        wrCfg   = 1'b0;
        wrCnt   = 1'b0;
        wrPad   = 1'b0;
        wrM0    = 1'b0;
        wrM1    = 1'b0;
        wrFc    = 1'b0;
        st_d    = st_q;
        doneEvt = '0;
        // Read data live one cycle only, zero otherwise
        st_d.rdata = '0;
        for (int n = 0; n < NSTREAM; n++) begin
            s     = st_q.strm[n];
            wrCfg = regWr && (regAddr == stAddr(n, OFF_CFG));
            wrCnt = regWr && (regAddr == stAddr(n, OFF_COUNT));
            wrPad = regWr && (regAddr == stAddr(n, OFF_PADDR));
            wrM0  = regWr && (regAddr == stAddr(n, OFF_FIRST_BUFFER_ADDRESS));
            wrM1  = regWr && (regAddr == stAddr(n, OFF_SECOND_BUFFER_ADDRESS));
            wrFc  = regWr && (regAddr == stAddr(n, OFF_FCTRL));

            // Configuration word
            if (wrCfg) begin
                if (!st_q.strm[n].en) begin
                    if (regWdata[CFG_DIR_LSB +: 2] != DSACF_RSVD) begin
                        s.dir = dsacf_dir_e'(regWdata[CFG_DIR_LSB +: 2]);
                    end
                    s.circ   = regWdata[CFG_CIRC_BIT];
                    s.double_buffer_mode    = regWdata[CFG_DBM_BIT];
                    s.mburst = dsacf_burst_e'(regWdata[CFG_MBURST_LSB +: 2]);
                    s.request_channel_select  = regWdata[CFG_REQUEST_CHANNEL_SELECT_LSB +: 3];
                end
                s.target = regWdata[CFG_TARG_BIT];
                if (regWdata[CFG_EN_BIT] && !st_q.strm[n].en) begin
                    s.count = s.orig;
                end
                s.en = regWdata[CFG_EN_BIT];
            end

            if (wrCnt && !st_q.strm[n].en) begin
                s.count = regWdata[COUNT_W-1:0];
                s.orig  = regWdata[COUNT_W-1:0];
            end

            if (wrPad && !st_q.strm[n].en) begin
                s.paddr = regWdata;
            end
            // first buffer free unless the stream is enabled with target clear
            if (wrM0 && (!st_q.strm[n].en || st_q.strm[n].target)) begin
                s.first_buffer_address = regWdata;
            end
            // second buffer free unless the stream is enabled with target set
            if (wrM1 && (!st_q.strm[n].en || !st_q.strm[n].target)) begin
                s.second_buffer_address = regWdata;
            end

            // FIFO control word
            if (wrFc) begin
                s.fth = regWdata[FC_FTH_LSB +: 2];
                s.fifo_error_irq_enable = regWdata[FC_FIFO_ERROR_IRQ_ENABLE_BIT];
                if (!st_q.strm[n].en) begin
                    s.dmOff = regWdata[FC_DMOFF_BIT];
                end
            end

            if (st_q.strm[n].en && (st_q.strm[n].dir == DSACF_M2M)) begin
                s.dmOff = 1'b1;
            end

            // Item completion; an empty counter ignores stray pulses
            // count down per completed item
            if (st_q.strm[n].en && itemDone[n] && (st_q.strm[n].count != 16'h0000)) begin
                if (st_q.strm[n].count == 16'h0001) begin
                    doneEvt[n] = 1'b1;
                    if (st_q.strm[n].double_buffer_mode) begin
                        s.target = ~st_q.strm[n].target;
                    end
                    // circular reload, else finish at zero
                    if (st_q.strm[n].circ) begin
                        s.count = st_q.strm[n].orig;
                    end else begin
                        s.count = 16'h0000;
                        s.en    = 1'b0;
                    end
                end else begin
                    s.count = st_q.strm[n].count - 16'h0001;
                end
            end
            st_d.strm[n] = s;

            // Read mux, from the values before this cycle's write
            if (regRd) begin
                if (regAddr == stAddr(n, OFF_CFG)) begin
                    st_d.rdata = cfgView(st_q.strm[n]);
                end
                // high half of the counter reads zero
                if (regAddr == stAddr(n, OFF_COUNT)) begin
                    st_d.rdata = {16'h0000, st_q.strm[n].count};
                end
                if (regAddr == stAddr(n, OFF_PADDR)) begin
                    st_d.rdata = st_q.strm[n].paddr;
                end
                if (regAddr == stAddr(n, OFF_FIRST_BUFFER_ADDRESS)) begin
                    st_d.rdata = st_q.strm[n].first_buffer_address;
                end
                if (regAddr == stAddr(n, OFF_SECOND_BUFFER_ADDRESS)) begin
                    st_d.rdata = st_q.strm[n].second_buffer_address;
                end
                // bit 6 and the top bits read zero
                if (regAddr == stAddr(n, OFF_FCTRL)) begin
                    st_d.rdata = {24'h000000, st_q.strm[n].fifo_error_irq_enable, 1'b0,
                                  fifoLevel[3*n +: 3], st_q.strm[n].dmOff,
                                  st_q.strm[n].fth};
                end
            end
        end
        // Interrupt registers; unmapped reads give zero
        if (regRd && (regAddr == OFF_IRQ_STATUS)) begin
            st_d.rdata = {16'h0000, irqStatus};
        end
        if (regRd && (regAddr == OFF_IRQ_MASK)) begin
            st_d.rdata = {16'h0000, irqMask};
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= RESET_REGS;
        end else begin
            st_q <= st_d;
        end
    end

    assign regRdata    = st_q.rdata;
    assign wrIrqStatus = regWr && (regAddr == OFF_IRQ_STATUS);
    assign wrIrqMask   = regWr && (regAddr == OFF_IRQ_MASK);

    // Status bits: low half completions, high half FIFO faults
    dsacf_irq u_irq (
        .clk      (clk),
        .nrst     (nrst),
        .evt      ({fifoErrEvt, doneEvt}),
        .wrStatus (wrIrqStatus),
        .wrMask   (wrIrqMask),
        .wdata    (regWdata[NEVT-1:0]),
        .status   (irqStatus),
        .mask     (irqMask),
        .irq      (irq)
    );

    // Per-stream outputs towards the transfer engine
    for (genvar n = 0; n < NSTREAM; n++) begin : g_strm
        // FIFO fault reaches status only when enabled
        assign fifoErrEvt[n]          = fifoError[n] && st_q.strm[n].fifo_error_irq_enable;
        assign streamEnable[n]        = st_q.strm[n].en;
        assign directMode[n]          = !st_q.strm[n].dmOff;
        assign transferDir[2*n +: 2]  = st_q.strm[n].dir;
        assign streamReq[n]           = chanReq[NCHAN*n + int'(st_q.strm[n].request_channel_select)];
        assign memBurstBeats[5*n +: 5] = burstBeats(st_q.strm[n].mburst, !st_q.strm[n].dmOff);
        // quarters of capacity, zero in direct mode
        assign fifoThreshold[3*n +: 3] = st_q.strm[n].dmOff ?
                                         ({1'b0, st_q.strm[n].fth} + 3'h1) : 3'h0;
        assign periphAddr[32*n +: 32] = st_q.strm[n].paddr;
        // Second buffer is only used in double-buffer mode
        assign memAddr[32*n +: 32]    = (st_q.strm[n].double_buffer_mode && st_q.strm[n].target) ?
                                        st_q.strm[n].second_buffer_address : st_q.strm[n].first_buffer_address;

        AST_BURST_DECODE: assert property (@(posedge clk) disable iff (!nrst)
            (st_q.strm[n].dmOff && st_q.strm[n].mburst == DSACF_INCR16)
            |-> (memBurstBeats[5*n +: 5] == BEATS_INCR16))
            else $error("burst code not decoded to sixteen beats");

        AST_DIRECT_SINGLE: assert property (@(posedge clk) disable iff (!nrst)
            directMode[n] |-> (memBurstBeats[5*n +: 5] == BEATS_SINGLE))
            else $error("burst not single in direct mode");

        AST_REQ_SELECT: assert property (@(posedge clk) disable iff (!nrst)
            streamReq[n] == chanReq[NCHAN*n + int'(st_q.strm[n].request_channel_select)])
            else $error("wrong request line selected");

        AST_COUNT_HELD: assert property (@(posedge clk) disable iff (!nrst)
            (st_q.strm[n].en && !itemDone[n] && regWr)
            |=> (st_q.strm[n].count == $past(st_q.strm[n].count)))
            else $error("counter changed by software while enabled");

        AST_COUNT_DOWN: assert property (@(posedge clk) disable iff (!nrst)
            (st_q.strm[n].en && itemDone[n] && st_q.strm[n].count > 16'h0001)
            |=> (st_q.strm[n].count == $past(st_q.strm[n].count) - 16'h0001))
            else $error("counter did not step down by one");

        AST_FINISH_ZERO: assert property (@(posedge clk) disable iff (!nrst)
            (st_q.strm[n].en && itemDone[n] && !st_q.strm[n].circ
             && st_q.strm[n].count == 16'h0001)
            |=> (st_q.strm[n].count == 16'h0000 && !st_q.strm[n].en && doneEvt[n] == 1'b0))
            else $error("finished stream not zero and disabled");

        AST_ENABLE_RELOAD: assert property (@(posedge clk) disable iff (!nrst)
            $rose(st_q.strm[n].en) |-> (st_q.strm[n].count == st_q.strm[n].orig))
            else $error("count not reloaded on enable");

        AST_PADDR_LOCK: assert property (@(posedge clk) disable iff (!nrst)
            (st_q.strm[n].en && regWr && regAddr == stAddr(n, OFF_PADDR))
            |=> $stable(st_q.strm[n].paddr))
            else $error("peripheral address written while enabled");

        AST_M0_LOCK: assert property (@(posedge clk) disable iff (!nrst)
            (st_q.strm[n].en && !st_q.strm[n].target && regWr
             && regAddr == stAddr(n, OFF_FIRST_BUFFER_ADDRESS))
            |=> $stable(st_q.strm[n].first_buffer_address))
            else $error("first buffer written while in use");

        AST_M1_LOCK: assert property (@(posedge clk) disable iff (!nrst)
            (st_q.strm[n].en && st_q.strm[n].target && regWr
             && regAddr == stAddr(n, OFF_SECOND_BUFFER_ADDRESS))
            |=> $stable(st_q.strm[n].second_buffer_address))
            else $error("second buffer written while in use");

        AST_FORCE_FIFO: assert property (@(posedge clk) disable iff (!nrst)
            (st_q.strm[n].en && st_q.strm[n].dir == DSACF_M2M) |=> st_q.strm[n].dmOff)
            else $error("memory copy left in direct mode");

        AST_FIFO_ERR_GATE: assert property (@(posedge clk) disable iff (!nrst)
            (fifoError[n] && !st_q.strm[n].fifo_error_irq_enable && !irqStatus[NSTREAM+n])
            |=> !irqStatus[NSTREAM+n])
            else $error("suppressed FIFO error raised status");
    end

    // Reserved direction code never stored
    AST_DIR_NOT_RSVD: assert property (@(posedge clk) disable iff (!nrst)
        st_q.strm[0].dir != DSACF_RSVD)
        else $error("reserved direction code stored");

    // Read data stand exactly one cycle after a read strobe
    AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (!nrst)
        !$past(regRd) |-> (regRdata == 32'h00000000))
        else $error("read data present without a read");

endmodule

`default_nettype wire

// *** dsacf_regs_tb.sv ***
/* Self-checking bench of the stream register bank.
   Assumes a one-cycle read latency and a model engine. */
`timescale 1ns/100ps
`default_nettype none
module dsacf_regs_tb;
    logic clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [7:0] kick = 8'h00, fault = 8'h00, itemDone, fifoError, streamEnable, streamReq;
    logic [7:0] directMode;
    logic [23:0] fifoLevel, fifoThreshold;
    logic [63:0] chanReq;
    logic [39:0] memBurstBeats;
    logic [15:0] transferDir;
    logic [255:0] periphAddr, memAddr;
    logic irq;
    int err_count = 0, n_checks = 0;
    dsacf_regs dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .itemDone(itemDone),
        .fifoError(fifoError), .fifoLevel(fifoLevel), .chanReq(chanReq),
        .streamEnable(streamEnable), .streamReq(streamReq), .directMode(directMode),
        .transferDir(transferDir), .memBurstBeats(memBurstBeats),
        .fifoThreshold(fifoThreshold), .periphAddr(periphAddr), .memAddr(memAddr), .irq(irq));
    dsacf_engine_model eng (.clk(clk), .kick(kick), .fault(fault), .itemDone(itemDone),
        .fifoError(fifoError), .fifoLevel(fifoLevel), .chanReq(chanReq));
    // 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) begin regWr <= 1'b1; regAddr <= a; regWdata <= d; end
        @(posedge clk) regWr <= 1'b0;
    endtask
    // Read data lands one cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk) begin regRd <= 1'b1; regAddr <= a; end
        @(posedge clk) regRd <= 1'b0;
        #1 chk(regRdata, exp);
    endtask
    task automatic item(input logic [7:0] k, input logic [7:0] f);
        @(posedge clk) begin kick <= k; fault <= f; end
        @(posedge clk) begin kick <= 8'h00; fault <= 8'h00; end
    endtask
    task automatic t_reset();
        rd(12'h014, 32'h0);
        rd(12'h024, 32'h10);
    endtask
    task automatic t_count();
        wr(12'h014, 32'hffff0002);
        rd(12'h014, 32'h2);
        wr(12'h02c, 32'h5);
        rd(12'h02c, 32'h5);
        rd(12'h014, 32'h2);
    endtask
    task automatic t_run();
        wr(12'h104, 32'h1);
        wr(12'h010, 32'h06800001);
        rd(12'h010, 32'h06000001);
        chk({27'h0, memBurstBeats[4:0]}, 32'h1);
        chk({31'h0, streamReq[0]}, 32'h1);
        wr(12'h018, 32'hbb);
        rd(12'h018, 32'h0);
        wr(12'h01c, 32'h11);
        wr(12'h020, 32'h22);
        rd(12'h01c, 32'h0);
        rd(12'h020, 32'h22);
        wr(12'h014, 32'h9);
        item(8'h01, 8'h00);
        rd(12'h014, 32'h1);
        item(8'h01, 8'h00);
        rd(12'h014, 32'h0);
        chk({streamEnable, 23'h0, irq}, 32'h1);
        wr(12'h100, 32'h1);
        #1 chk({31'h0, irq}, 32'h0);
        wr(12'h010, 32'h1);
        rd(12'h014, 32'h2);
    endtask
    // Stream 1: FIFO faults, memory copy, double buffer, direction
    task automatic t_mode();
        item(8'h00, 8'h02);
        rd(12'h100, 32'h0);
        wr(12'h03c, 32'h83);
        item(8'h00, 8'h02);
        rd(12'h100, 32'h200);
        chk({29'h0, fifoThreshold[5:3]}, 32'h0);
        wr(12'h02c, 32'h1);
        wr(12'h030, 32'h1234);
        wr(12'h038, 32'hbb);
        wr(12'h028, 32'h01840081);
        rd(12'h03c, 32'h87);
        chk({31'h0, directMode[1]}, 32'h0);
        chk({27'h0, memBurstBeats[9:5]}, 32'h10);
        chk({29'h0, fifoThreshold[5:3]}, 32'h4);
        chk({30'h0, transferDir[3:2]}, 32'h2);
        chk(periphAddr[63:32], 32'h1234);
        wr(12'h034, 32'haa);
        #1 chk(memAddr[63:32], 32'h0);
        wr(12'h028, 32'h00080001);
        rd(12'h028, 32'h018c0081);
        chk(memAddr[63:32], 32'hbb);
        wr(12'h034, 32'haa);
        rd(12'h034, 32'haa);
        item(8'h02, 8'h00);
        rd(12'h028, 32'h01840080);
        chk(memAddr[63:32], 32'haa);
        wr(12'h028, 32'hc0);
        rd(12'h028, 32'h80);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_count();
        t_run();
        t_mode();
        summarize();
    end
    // Watchdog, far beyond the hundred or so cycles needed
    initial begin
        #500000;
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
